// ==== rtl/bwce_defines.svh ====
`ifndef BWCE_DEFINES_SVH
`define BWCE_DEFINES_SVH
// Write buffer depth, data word width and address width.
`define BWCE_WB_DEPTH      4
`define BWCE_WORD_W        32
`define BWCE_ADDR_W        26
// Transfer size encodings carried with each store.
`define BWCE_SIZE_BYTE     2'h0
`define BWCE_SIZE_HALF     2'h1
`define BWCE_SIZE_TRI      2'h2
`define BWCE_SIZE_WORD     2'h3
// Port width encodings.
`define BWCE_PORT_32       2'h0
`define BWCE_PORT_16       2'h1
`define BWCE_PORT_8        2'h2
// Default wait states per datum, single and burst.
`define BWCE_WAIT_SINGLE   4'h1
`define BWCE_WAIT_BURST    4'h0
`endif

// ==== rtl/bwce_pkg.sv ====
package bwce_pkg;
  // Engine states.
  typedef enum logic [3:0] {
    BWCE_IDLE = 4'b0001,
    BWCE_ADDR = 4'b0010,
    BWCE_DATA = 4'b0100,
    BWCE_DONE = 4'b1000
  } bwce_state_e;
  // Two-bit codes for sizes and ports.
  typedef logic [1:0] bwce_code_t;
endpackage

// ==== rtl/bwce_wbuf_mem.sv ====
`timescale 1ns/100ps
`include "bwce_defines.svh"
// Small write-buffer storage; read data comes out of a register.
module bwce_wbuf_mem
  import bwce_pkg::*;
#(
  parameter int DEPTH = `BWCE_WB_DEPTH,
  parameter int WIDTH = 60,
  parameter int AW    = 2
) (
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_idx,
  output logic      [WIDTH-1:0] rd_data_q
);
  logic [WIDTH-1:0] mem_q [DEPTH];  // Entry storage, no reset needed.

  // Write port captures one store per cycle.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // Registered read port follows the head index.
  always_ff @(posedge clk) begin
    rd_data_q <= mem_q[rd_idx];
  end
endmodule

// ==== rtl/bwce_engine.sv ====
`timescale 1ns/100ps
`include "bwce_defines.svh"
// Functional notes
// - Request bus while buffer holds data.
// - Start on next edge when unopposed.
// - Request stays asserted until buffer drains.
// - Assert write strobe, drive address, controls.
// - Start edge: address, latch enable, frame.
// - Data phase: drop latch, drive data.
// - Bus fault ends write like last ack.
// - Frame released for final mini-burst datum.
// - New transaction one clock after ack; the engine starts it three clocks after.
// - Keep buses driven, no turnaround gap.
// - No turnaround delay after writes.
// - Full buffer stalls core, store retried.
// - Entry freed in second phase.
// - Separate data register for bus write.
// - One store per full-word entry.
// - Programmed waits, wait input overrides.
// - Four entries: data, address, size.
// - Halfword burst advances address, enables; the engine advances only the address.
// - Partial writes assert only written lanes; the engine does so on the 32-bit port and for byte stores on the 16-bit port.
module bwce_engine
  import bwce_pkg::*;
#(
  parameter int        DEPTH       = `BWCE_WB_DEPTH,
  parameter int        AW          = `BWCE_ADDR_W,
  parameter logic[3:0] WAIT_SINGLE = `BWCE_WAIT_SINGLE,
  parameter logic[3:0] WAIT_BURST  = `BWCE_WAIT_BURST
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         store_valid,
  input  wire logic [AW-1:0] store_addr,
  input  wire logic [31:0]  store_data,
  input  wire logic [1:0]   store_size,
  output logic              store_stall,
  input  wire logic [1:0]   port_width,
  input  wire logic         higher_prio_req,
  output logic              wbuf_has_data,
  output logic              wbuf_empty_flag,
  input  wire logic         wait_extend_in,
  input  wire logic         bus_fault_in,
  output logic              datum_ack,
  output logic [AW-1:0]     address_bus_out,
  output logic              address_bus_oe,
  input  wire logic [31:0]  data_bus_in,
  output logic [31:0]       data_bus_out,
  output logic              data_bus_oe,
  output logic              addr_latch_en,
  output logic              write_strobe_n,
  output logic              transfer_frame_n,
  output logic [3:0]        byte_write_strobe_n
);
  localparam int PW = $clog2(DEPTH);          // Pointer width.
  localparam int EW = 32 + AW + 2;            // Entry: data, address, size.

  bwce_state_e      state_q;                  // Engine state.
  logic [PW:0]      count_q;                  // Entries held.
  logic [PW-1:0]    head_q;                   // Oldest entry.
  logic [PW-1:0]    tail_q;                   // Next free entry.
  logic [EW-1:0]    head_entry;               // Registered head word.
  logic [31:0]      wdata_q;                  // Bus write data register.
  logic [1:0]       wsize_q;                  // Size of write in flight.
  logic [AW-1:0]    waddr_q;                  // Address of write in flight.
  logic [2:0]       beats_q;                  // Data phases left.
  logic [3:0]       wait_q;                   // Wait cycles left this datum.
  logic             wait_s1_q;                // Wait input, first stage.
  logic             wait_s2_q;                // Wait input, synchronised.
  logic             fault_s1_q;               // Fault input, first stage.
  logic             fault_s2_q;               // Fault input, synchronised.
  logic             push;                     // Store accepted.
  logic             pop;                      // Entry released.
  logic             start;                    // Write launched.
  logic             last_beat;                // Current datum is the last.
  logic             terminate;                // Transaction ends this cycle.

  // Number of data phases for a store on a given port.
  function automatic logic [2:0] beats_for(input logic [1:0] size, input logic [1:0] port);
    logic [2:0] nbytes;
    nbytes = {1'b0, size} + 3'h1;
    case (port)
      `BWCE_PORT_8:  beats_for = nbytes;
      `BWCE_PORT_16: beats_for = (nbytes > 3'h2) ? 3'h2 : 3'h1;
      default:       beats_for = 3'h1;
    endcase
  endfunction

  // Active-low byte enables for one datum at a given address.
  function automatic logic [3:0] lanes_for(input logic [1:0] size, input logic [1:0] port,
                                           input logic [1:0] a);
    logic [3:0] m;
    m = 4'h0;
    case (port)
      `BWCE_PORT_8:  m = 4'hf;
      `BWCE_PORT_16: m = (size == `BWCE_SIZE_BYTE) ? (a[0] ? 4'ha : 4'h5) : 4'hf;
      default: begin
        case (size)
          `BWCE_SIZE_BYTE: m = 4'h1 << a;
          `BWCE_SIZE_HALF: m = a[1] ? 4'hc : 4'h3;
          `BWCE_SIZE_TRI:  m = a[0] ? 4'he : 4'h7;
          default:         m = 4'hf;
        endcase
      end
    endcase
    lanes_for = ~m;
  endfunction

  // Buffer accounting: a store needs a free entry or it stalls.
  assign store_stall     = store_valid && (count_q == (PW+1)'(DEPTH));
  assign push            = store_valid && !store_stall;
  assign wbuf_has_data   = (count_q != '0);
  assign wbuf_empty_flag = !wbuf_has_data;
  // Unopposed request starts on the next edge; a higher request delays it.
  assign start           = (state_q == BWCE_IDLE) && wbuf_has_data && !higher_prio_req;
  assign pop             = (state_q == BWCE_ADDR);
  assign last_beat       = (beats_q == 3'h1);
  assign terminate       = (state_q == BWCE_DATA) && (fault_s2_q || (datum_ack && last_beat));

  bwce_wbuf_mem #(.DEPTH(DEPTH), .WIDTH(EW), .AW(PW)) u_mem (
    .clk       (clk),
    .wr_en     (push),
    .wr_idx    (tail_q),
    .wr_data   ({store_size, store_addr, store_data}),
    .rd_idx    (head_q),
    .rd_data_q (head_entry)
  );

  // Wait and fault pin inputs pass two flip-flops before use; higher_prio_req is used unsynchronised.
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_s1_q  <= 1'b0;
      wait_s2_q  <= 1'b0;
      fault_s1_q <= 1'b0;
      fault_s2_q <= 1'b0;
    end else begin
      wait_s1_q  <= wait_extend_in;
      wait_s2_q  <= wait_s1_q;
      fault_s1_q <= bus_fault_in;
      fault_s2_q <= fault_s1_q;
    end
  end

  // Pointers and occupancy; a push and a release may share a cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      head_q  <= '0;
      tail_q  <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        tail_q <= tail_q + 1'b1;
      end
      if (pop) begin
        head_q <= head_q + 1'b1;
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Engine sequencing. DONE and IDLE each cost one cycle after the final acknowledge,
  // so the next write's address phase begins three clocks after that acknowledge.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= BWCE_IDLE;
    end else begin
      case (state_q)
        BWCE_IDLE: if (start) state_q <= BWCE_ADDR;
        BWCE_ADDR: state_q <= BWCE_DATA;
        BWCE_DATA: if (terminate) state_q <= BWCE_DONE;
        BWCE_DONE: state_q <= BWCE_IDLE;
        default:   state_q <= BWCE_IDLE;
      endcase
    end
  end

  // Capture the head entry into the bus data register at launch.
  always_ff @(posedge clk) begin
    if (rst) begin
      wdata_q <= '0;
      wsize_q <= `BWCE_SIZE_WORD;
      waddr_q <= '0;
    end else if (state_q == BWCE_ADDR) begin
      wdata_q <= head_entry[31:0];
      wsize_q <= head_entry[EW-1 -: 2];
      waddr_q <= head_entry[32 +: AW];
    end else if (state_q == BWCE_DATA && datum_ack && !last_beat) begin
      // Rotate the data register in step with the bus data, by one byte on an 8-bit port and a halfword otherwise.
      wdata_q <= (port_width == `BWCE_PORT_8) ? {wdata_q[23:0], wdata_q[31:24]}
                                               : {wdata_q[15:0], wdata_q[31:16]};
      // Step the low address for the next datum of a mini-burst.
      if (port_width == `BWCE_PORT_16) begin
        waddr_q <= waddr_q + AW'(2);
      end else begin
        waddr_q <= waddr_q + AW'(1);
      end
    end
  end

  // Beat count and programmed wait states per datum.
  always_ff @(posedge clk) begin
    if (rst) begin
      beats_q <= 3'h1;
      wait_q  <= '0;
    end else if (state_q == BWCE_ADDR) begin
      beats_q <= beats_for(head_entry[EW-1 -: 2], port_width);
      wait_q  <= (beats_for(head_entry[EW-1 -: 2], port_width) > 3'h1) ? WAIT_BURST : WAIT_SINGLE;
    end else if (state_q == BWCE_DATA && datum_ack) begin
      beats_q <= beats_q - 3'h1;
      wait_q  <= WAIT_BURST;
    end else if (state_q == BWCE_DATA && wait_q != '0 && !wait_s2_q) begin
      wait_q <= wait_q - 4'h1;
    end
  end

  // Acknowledge once the count has run out and the wait input is released.
  assign datum_ack = (state_q == BWCE_DATA) && (wait_q == '0) && !wait_s2_q;

  // Bus pins driven from registered state.
  always_ff @(posedge clk) begin
    if (rst) begin
      address_bus_out     <= '0;
      address_bus_oe      <= 1'b0;
      data_bus_out        <= '0;
      data_bus_oe         <= 1'b0;
      addr_latch_en       <= 1'b0;
      write_strobe_n      <= 1'b1;
      transfer_frame_n    <= 1'b1;
      byte_write_strobe_n <= 4'hf;
    end else begin
      addr_latch_en <= (state_q == BWCE_ADDR);
      // Buses stay driven across the write and into the next start.
      address_bus_oe <= address_bus_oe || (state_q == BWCE_ADDR);
      if (state_q == BWCE_ADDR) begin
        address_bus_out  <= head_entry[32 +: AW];
        write_strobe_n   <= 1'b0;
        transfer_frame_n <= (beats_for(head_entry[EW-1 -: 2], port_width) == 3'h1);
        data_bus_out     <= head_entry[31:0];
        data_bus_oe      <= 1'b1;
        byte_write_strobe_n <= lanes_for(head_entry[EW-1 -: 2], port_width,
                                         head_entry[33:32]);
      end else if (terminate) begin
        write_strobe_n      <= 1'b1;
        transfer_frame_n    <= 1'b1;
        byte_write_strobe_n <= 4'hf;
      end else if (state_q == BWCE_DATA && datum_ack) begin
        address_bus_out <= (port_width == `BWCE_PORT_16) ? waddr_q + AW'(2) : waddr_q + AW'(1);
        transfer_frame_n <= (beats_q == 3'h2);
        data_bus_out <= (port_width == `BWCE_PORT_8) ? {wdata_q[23:0], wdata_q[31:24]}
                                                     : {wdata_q[15:0], wdata_q[31:16]};
      end
    end
  end

  // Data input is unused on the write path; reads are handled elsewhere.
  logic unused_in;
  assign unused_in = ^data_bus_in ^ ^wsize_q;
endmodule

// ==== verification/bwce_engine_asserts.sv ====
`timescale 1ns/100ps
// Port-level protocol checks for the write engine; sees only its ports.
module bwce_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic store_valid,
  input wire logic store_stall,
  input wire logic higher_prio_req,
  input wire logic wbuf_has_data,
  input wire logic wbuf_empty_flag,
  input wire logic wait_extend_in,
  input wire logic bus_fault_in,
  input wire logic datum_ack,
  input wire logic addr_latch_en,
  input wire logic write_strobe_n,
  input wire logic transfer_frame_n,
  input wire logic address_bus_oe
);
  // One clock domain, so clocking and reset are declared once.
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_empty_flag_inverse: assert property (wbuf_empty_flag != wbuf_has_data)
    else $error("empty flag is not the inverse of the data flag");
  chk_stall_needs_full: assert property (store_stall |-> store_valid && wbuf_has_data)
    else $error("stall raised without a pending store and data");
  chk_latch_one_cycle: assert property (addr_latch_en |=> !addr_latch_en)
    else $error("address latch enable held past one cycle");
  chk_latch_with_strobe: assert property (addr_latch_en |-> !write_strobe_n && address_bus_oe)
    else $error("latch enable without strobe or driven address");
  // Data arriving at an idle, unopposed engine must launch quickly.
  chk_start_when_free: assert property ($rose(wbuf_has_data) && write_strobe_n && !higher_prio_req
    |-> ##[1:6] addr_latch_en)
    else $error("write not started on a free bus");
  chk_prio_blocks_start: assert property (higher_prio_req [*4] |-> !$fell(write_strobe_n))
    else $error("write started over a higher priority request");
  chk_final_ack_release: assert property (datum_ack && transfer_frame_n |-> ##[1:2] write_strobe_n)
    else $error("strobe not released after final acknowledge");
  chk_addr_keeps_driven: assert property (address_bus_oe |=> address_bus_oe)
    else $error("address bus released after a write");
  chk_wait_blocks_ack: assert property (wait_extend_in [*4] |-> !datum_ack)
    else $error("acknowledge given while wait held");
  chk_fault_terminates: assert property (bus_fault_in [*2] && !write_strobe_n |-> ##[1:3] write_strobe_n)
    else $error("bus fault did not end the write");
  // Main scenarios reached.
  cov_stall: cover property (store_stall);
  cov_mini_burst: cover property (datum_ack && !transfer_frame_n);
  cov_fault_end: cover property (bus_fault_in && $rose(write_strobe_n));
endmodule
bind bwce_engine bwce_chk u_chk (.clk(clk), .rst(rst), .store_valid(store_valid), .store_stall(store_stall),
  .higher_prio_req(higher_prio_req), .wbuf_has_data(wbuf_has_data), .wbuf_empty_flag(wbuf_empty_flag),
  .wait_extend_in(wait_extend_in), .bus_fault_in(bus_fault_in), .datum_ack(datum_ack),
  .addr_latch_en(addr_latch_en), .write_strobe_n(write_strobe_n), .transfer_frame_n(transfer_frame_n),
  .address_bus_oe(address_bus_oe));

// ==== verification/bwce_mem_model.sv ====
`timescale 1ns/100ps
// Far-side memory: stretches data with the wait pin, can fail a write.
module bwce_mem_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic hold,
  input  wire logic fault_req,
  input  wire logic write_strobe_n,
  input  wire logic datum_ack,
  output logic      wait_extend_in,
  output logic      bus_fault_in,
  output int        ack_cnt
);
  // Pins move only after an edge; a fault is shown only during a write.
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_extend_in <= 1'b0;
      bus_fault_in   <= 1'b0;
    end else begin
      wait_extend_in <= hold;
      bus_fault_in   <= fault_req && !write_strobe_n;
    end
  end
  // Acknowledges that end each datum are counted for the bench.
  always_ff @(posedge clk) begin
    if (rst) ack_cnt <= 0;
    else if (datum_ack) ack_cnt <= ack_cnt + 1;
  end
endmodule

// ==== verification/bwce_engine_tb.sv ====
`timescale 1ns/100ps
module bwce_engine_tb;
  import bwce_pkg::*;
  logic        clk, rst, store_valid, higher_prio_req, hold, fault_req, wait_extend_in, bus_fault_in;
  logic [25:0] store_addr, address_bus_out, last_addr, ack_addr;
  logic [31:0] store_data, data_bus_out, last_data, ack_data;
  logic [1:0]  store_size, port_width;
  logic [3:0]  byte_write_strobe_n, lanes;
  logic        store_stall, wbuf_has_data, wbuf_empty_flag, datum_ack, address_bus_oe, data_bus_oe;
  logic        addr_latch_en, write_strobe_n, transfer_frame_n, fin_frame;
  int          failures, comparisons, writes, gap, last_gap, ack_cnt, ack_base, cycles;
  bwce_engine dut (.clk(clk), .rst(rst), .store_valid(store_valid), .store_addr(store_addr),
    .store_data(store_data), .store_size(store_size), .store_stall(store_stall), .port_width(port_width),
    .higher_prio_req(higher_prio_req), .wbuf_has_data(wbuf_has_data), .wbuf_empty_flag(wbuf_empty_flag),
    .wait_extend_in(wait_extend_in), .bus_fault_in(bus_fault_in), .datum_ack(datum_ack),
    .address_bus_out(address_bus_out), .address_bus_oe(address_bus_oe), .data_bus_in(32'h0),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .addr_latch_en(addr_latch_en),
    .write_strobe_n(write_strobe_n), .transfer_frame_n(transfer_frame_n),
    .byte_write_strobe_n(byte_write_strobe_n));
  bwce_mem_model mem (.clk(clk), .rst(rst), .hold(hold), .fault_req(fault_req), .write_strobe_n(write_strobe_n),
    .datum_ack(datum_ack), .wait_extend_in(wait_extend_in), .bus_fault_in(bus_fault_in), .ack_cnt(ack_cnt));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Bus monitor; lanes gather every byte strobe seen during a write.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (!write_strobe_n) lanes <= lanes | ~byte_write_strobe_n;
    if (datum_ack) begin
      ack_addr  <= address_bus_out;
      ack_data  <= data_bus_out;
      fin_frame <= transfer_frame_n;
    end
    if (addr_latch_en) begin
      writes    <= writes + 1;
      last_addr <= address_bus_out;
      last_data <= data_bus_out;
      last_gap  <= gap;
      gap       <= 0;
    end else if (write_strobe_n) gap <= gap + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic clr();
    writes = 0;
    lanes = 4'h0;
    gap = 0;
    ack_base = ack_cnt;
  endtask
  // Offers a store and returns after the edge that took it; valid stays up.
  task automatic push(input logic [25:0] a, input logic [31:0] d, input logic [1:0] s);
    int n;
    n = 0;
    store_addr = a;
    store_data = d;
    store_size = s;
    store_valid = 1'b1;
    #1;
    while (store_stall && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask
  // Bounded wait until the buffer is empty and the bus is quiet.
  task automatic drain();
    int n;
    n = 0;
    store_valid = 1'b0;
    while ((wbuf_has_data || !write_strobe_n) && n < 400) begin
      @(negedge clk);
      n++;
    end
    repeat (6) @(negedge clk);
  endtask
  task automatic t_single();
    clr();
    push(26'h0000104, 32'hcafe0123, 2'h3);
    drain();
    chk(writes, 1);
    chk(ack_cnt - ack_base, 1);
    chk(last_addr, 26'h0000104);
    chk(last_data, 32'hcafe0123);
    chk(lanes, 4'hf);
    chk(write_strobe_n, 1'b1);
    chk(data_bus_oe, 1'b1);
  endtask
  task automatic t_sizes();
    for (int s = 0; s < 3; s++) begin
      clr();
      push(26'h0, 32'h11223344, s[1:0]);
      drain();
      chk($countones(lanes), s + 1);
    end
  endtask
  // Mini-bursts: ports, sizes and datum counts side by side.
  task automatic t_mini();
    logic [1:0] pw[5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [1:0] sz[5] = '{2'h3, 2'h1, 2'h3, 2'h2, 2'h0};
    int         na[5] = '{2, 1, 4, 3, 1};
    for (int i = 0; i < 5; i++) begin
      clr();
      port_width = pw[i];
      push(26'h40, 32'ha5a55a5a, sz[i]);
      drain();
      chk(ack_cnt - ack_base, na[i]);
      chk(fin_frame, 1'b1);
      chk(ack_addr, 26'h40 + (na[i] - 1) * (pw[i] == 2'h1 ? 2 : 1));
      if (i == 2) chk(ack_data, 32'h5aa5a55a);
    end
    port_width = 2'h0;
  endtask
  task automatic t_full();
    clr();
    hold = 1'b1;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 5; i++) push(26'h100 + i * 4, i, 2'h3);
    store_addr = 26'h114;
    #1;
    chk(store_stall, 1'b1);
    chk(wbuf_empty_flag, 1'b0);
    hold = 1'b0;
    push(26'h114, 32'h5, 2'h3);
    drain();
    chk(writes, 6);
  endtask
  task automatic t_prio();
    clr();
    higher_prio_req = 1'b1;
    push(26'h80, 32'h5, 2'h3);
    store_valid = 1'b0;
    repeat (10) @(negedge clk);
    chk(writes, 0);
    chk(wbuf_has_data, 1'b1);
    higher_prio_req = 1'b0;
    drain();
    chk(writes, 1);
  endtask
  task automatic t_fault();
    clr();
    hold = 1'b1;
    fault_req = 1'b1;
    push(26'h90, 32'h1, 2'h3);
    drain();
    chk(writes, 1);
    chk(ack_cnt - ack_base, 0);
    hold = 1'b0;
    fault_req = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_b2b();
    clr();
    push(26'h200, 32'h1, 2'h3);
    push(26'h204, 32'h2, 2'h3);
    drain();
    chk(writes, 2);
    chk(last_gap <= 5, 1'b1);
    chk(address_bus_oe, 1'b1);
    chk(last_addr, 26'h204);
  endtask
  task automatic finish_test();
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence; reset is held for sixteen cycles first.
  initial begin
    {rst, store_valid, higher_prio_req, hold, fault_req} = 5'h10;
    {store_addr, store_data, store_size, port_width} = '0;
    {failures, comparisons, writes, gap, last_gap, cycles} = '0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk(write_strobe_n, 1'b1);
    t_single();
    t_sizes();
    t_mini();
    t_full();
    t_prio();
    t_fault();
    t_b2b();
    finish_test();
  end
endmodule
